// File: include/mtrmux_pkg.sv
package mtrmux_pkg;

  // ***************************************************************
  // Register byte offsets.
  // ***************************************************************
  localparam logic [7:0] MTRMUX_OFF_PC_DATA = 8'h00;
  localparam logic [7:0] MTRMUX_OFF_PC_DIR = 8'h04;
  localparam logic [7:0] MTRMUX_OFF_PC_OPT = 8'h08;
  localparam logic [7:0] MTRMUX_OFF_PD_DATA = 8'h0c;
  localparam logic [7:0] MTRMUX_OFF_PD_DIR = 8'h10;
  localparam logic [7:0] MTRMUX_OFF_PD_OPT = 8'h14;
  localparam logic [7:0] MTRMUX_OFF_PF_DATA = 8'h18;
  localparam logic [7:0] MTRMUX_OFF_PF_DIR = 8'h1c;
  localparam logic [7:0] MTRMUX_OFF_PF_OPT = 8'h20;
  localparam logic [7:0] MTRMUX_OFF_MOTOR_REFERENCE_REGISTER = 8'h24;
  localparam logic [7:0] MTRMUX_OFF_MOTOR_CONTROL_REGISTER_A = 8'h28;
  localparam logic [7:0] MTRMUX_OFF_PIN_C = 8'h2c;
  localparam logic [7:0] MTRMUX_OFF_PIN_D = 8'h30;
  localparam logic [7:0] MTRMUX_OFF_PIN_F = 8'h34;
  localparam logic [7:0] MTRMUX_OFF_MIN = 8'h38;

  // ***************************************************************
  // Field positions.
  // ***************************************************************
  localparam int MTRMUX_BIT_FAULT_SEL = 0;
  localparam int MTRMUX_BIT_CKE = 0;
  localparam int MTRMUX_BIT_DAC = 1;
  localparam int MTRMUX_BIT_SHARED_PC = 4;
  localparam int MTRMUX_BIT_GEN_PC = 1;
  localparam int MTRMUX_BIT_V_PC = 6;
  localparam int MTRMUX_BIT_W_PC = 7;
  localparam int MTRMUX_BIT_V_PD = 1;
  localparam int MTRMUX_BIT_W_PD = 0;
  localparam int MTRMUX_BIT_ZC_PF = 1;
  localparam int MTRMUX_BIT_DM_PF = 0;
  localparam int MTRMUX_BIT_ZC_PD = 2;
  localparam int MTRMUX_BIT_DM_PD = 1;

  // ***************************************************************
  // Reset values and package sizes.
  // ***************************************************************
  localparam logic [7:0] MTRMUX_DATA_RST = 8'h00;
  localparam logic [7:0] MTRMUX_DIR_RST = 8'h00;
  localparam logic MTRMUX_FAULT_SEL_RST = 1'b1;
  localparam int MTRMUX_PINS_DEF = 80;
  localparam int MTRMUX_PORTS = 3;
  localparam int MTRMUX_PADS = 8;

endpackage

// File: hdl/mtrmux_port.sv
`timescale 1ns/1ps
module mtrmux_port #(
  parameter logic [7:0] INT_CAP = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] data,
  input wire logic [7:0] dir,
  input wire logic [7:0] opt,
  input wire logic [7:0] alt_val,
  input wire logic [7:0] alt_en,
  input wire logic [7:0] analog,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe_n,
  output logic [7:0] pad_pu,
  output logic [7:0] pin_level,
  output logic [7:0] ext_int
);
  import mtrmux_pkg::*;

  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;
  logic [7:0] lvl_r;
  logic [7:0] lvl_nxt;

  // ***************************************************************
  // Per-pad drive and input filter.
  // ***************************************************************
  genvar i;
  generate
    for (i = 0; i < MTRMUX_PADS; i = i + 1) begin : g_pad
      always_comb begin
        lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
        if (analog[i]) begin
          // Analog pads neither drive nor pull so the cell sees the pin.
          pad_out[i] = 1'b0;
          pad_oe_n[i] = 1'b1;
          pad_pu[i] = 1'b0;
        end else if (alt_en[i]) begin
          pad_out[i] = alt_val[i];
          pad_oe_n[i] = 1'b0;
          pad_pu[i] = 1'b0;
        end else if (dir[i]) begin
          // Option set means push-pull; clear means open drain.
          pad_out[i] = data[i];
          pad_oe_n[i] = ~(opt[i] | ~data[i]);
          pad_pu[i] = 1'b0;
        end else begin
          pad_out[i] = 1'b0;
          pad_oe_n[i] = 1'b1;
          pad_pu[i] = opt[i];
        end
        pin_level[i] = analog[i] ? 1'b0 : lvl_r[i];
        ext_int[i] = INT_CAP[i] & ~dir[i] & ~analog[i] & lvl_r[i];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
      lvl_r <= 8'h00;
    end else begin
      s1_r <= pad_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

endmodule // mtrmux_port

// File: hdl/mtrmux_top.sv
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module mtrmux_top #(
  parameter int PKG_PINS = mtrmux_pkg::MTRMUX_PINS_DEF,
  parameter logic [7:0] PC_BONDED = 8'hff,
  parameter logic [7:0] PD_BONDED = 8'hff,
  parameter logic [7:0] PF_BONDED = 8'hff,
  parameter logic [7:0] PC_INT_CAP = 8'h00,
  parameter logic [7:0] PD_INT_CAP = 8'hfe,
  parameter logic [7:0] PF_INT_CAP = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic phase_v_pwm_out,
  input wire logic phase_v_pwm_en,
  input wire logic phase_w_pwm_out,
  input wire logic phase_w_pwm_en,
  input wire logic [7:0] alt_c_val,
  input wire logic [7:0] alt_c_en,
  input wire logic [7:0] alt_d_val,
  input wire logic [7:0] alt_d_en,
  input wire logic [7:0] alt_f_val,
  input wire logic [7:0] alt_f_en,
  input wire logic amplifier_output_pad,
  input wire logic [7:0] pad_c_in,
  output logic [7:0] pad_c_out,
  output logic [7:0] pad_c_oe_n,
  output logic [7:0] pad_c_pu,
  input wire logic [7:0] pad_d_in,
  output logic [7:0] pad_d_out,
  output logic [7:0] pad_d_oe_n,
  output logic [7:0] pad_d_pu,
  input wire logic [7:0] pad_f_in,
  output logic [7:0] pad_f_out,
  output logic [7:0] pad_f_oe_n,
  output logic [7:0] pad_f_pu,
  output logic [7:0] ext_int_c,
  output logic [7:0] ext_int_d,
  output logic [7:0] ext_int_f,
  output logic current_fault_input,
  output logic zero_cross_input,
  output logic demag_input,
  output logic shared_pin_to_motor
);
  import mtrmux_pkg::*;

  // ***************************************************************
  // Package variant decode.
  // ***************************************************************
  localparam logic PKG_GE56 = (PKG_PINS >= 56);
  localparam logic PKG_GE64 = (PKG_PINS >= 64);
  localparam logic PKG_IS32 = (PKG_PINS == 32);
  // Unbonded pads come out of reset with the pull-up option set.
  localparam logic [7:0] PC_OPT_RST = ~PC_BONDED;
  localparam logic [7:0] PD_OPT_RST = ~PD_BONDED;
  localparam logic [7:0] PF_OPT_RST = ~PF_BONDED;

  logic [7:0] c_data_r, c_dir_r, c_opt_r;
  logic [7:0] d_data_r, d_dir_r, d_opt_r;
  logic [7:0] f_data_r, f_dir_r, f_opt_r;
  logic fault_sel_r, cke_r, dac_r;
  logic [7:0] c_data_nxt, c_dir_nxt, c_opt_nxt;
  logic [7:0] d_data_nxt, d_dir_nxt, d_opt_nxt;
  logic [7:0] f_data_nxt, f_dir_nxt, f_opt_nxt;
  logic fault_sel_nxt, cke_nxt, dac_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [2:0] amp_sync_r;
  logic amp_lvl_r, amp_lvl_nxt;
  logic fault_r, zc_r, dm_r;
  logic fault_nxt, zc_nxt, dm_nxt;
  logic wr_fire;
  logic motor_on;
  logic [7:0] c_lvl, d_lvl, f_lvl;
  logic [7:0] c_alt_v, c_alt_e, d_alt_v, d_alt_e, c_analog;

  // ***************************************************************
  // Alternate function routing.
  // ***************************************************************
  assign motor_on = cke_r | dac_r;
  assign shared_pin_to_motor = motor_on;
  assign c_analog = 8'(motor_on) << MTRMUX_BIT_SHARED_PC;

  always_comb begin
    c_alt_v = alt_c_val & alt_c_en;
    c_alt_e = alt_c_en;
    d_alt_v = alt_d_val & alt_d_en;
    d_alt_e = alt_d_en;
    if (PKG_GE64) begin
      c_alt_e[MTRMUX_BIT_V_PC] = alt_c_en[MTRMUX_BIT_V_PC] | phase_v_pwm_en;
      c_alt_v[MTRMUX_BIT_V_PC] = c_alt_v[MTRMUX_BIT_V_PC] |
        (phase_v_pwm_en & phase_v_pwm_out);
    end else begin
      d_alt_e[MTRMUX_BIT_V_PD] = alt_d_en[MTRMUX_BIT_V_PD] | phase_v_pwm_en;
      d_alt_v[MTRMUX_BIT_V_PD] = d_alt_v[MTRMUX_BIT_V_PD] |
        (phase_v_pwm_en & phase_v_pwm_out);
    end
    if (PKG_IS32) begin
      d_alt_e[MTRMUX_BIT_W_PD] = alt_d_en[MTRMUX_BIT_W_PD] | phase_w_pwm_en;
      d_alt_v[MTRMUX_BIT_W_PD] = d_alt_v[MTRMUX_BIT_W_PD] |
        (phase_w_pwm_en & phase_w_pwm_out);
    end else begin
      c_alt_e[MTRMUX_BIT_W_PC] = alt_c_en[MTRMUX_BIT_W_PC] | phase_w_pwm_en;
      c_alt_v[MTRMUX_BIT_W_PC] = c_alt_v[MTRMUX_BIT_W_PC] |
        (phase_w_pwm_en & phase_w_pwm_out);
    end
  end

  mtrmux_port #(.INT_CAP(PC_INT_CAP)) u_port_c (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .data(c_data_r),
    .dir(c_dir_r),
    .opt(c_opt_r),
    .alt_val(c_alt_v),
    .alt_en(c_alt_e),
    .analog(c_analog),
    .pad_in(pad_c_in),
    .pad_out(pad_c_out),
    .pad_oe_n(pad_c_oe_n),
    .pad_pu(pad_c_pu),
    .pin_level(c_lvl),
    .ext_int(ext_int_c)
  );

  mtrmux_port #(.INT_CAP(PD_INT_CAP)) u_port_d (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .data(d_data_r),
    .dir(d_dir_r),
    .opt(d_opt_r),
    .alt_val(d_alt_v),
    .alt_en(d_alt_e),
    .analog(8'h00),
    .pad_in(pad_d_in),
    .pad_out(pad_d_out),
    .pad_oe_n(pad_d_oe_n),
    .pad_pu(pad_d_pu),
    .pin_level(d_lvl),
    .ext_int(ext_int_d)
  );

  mtrmux_port #(.INT_CAP(PF_INT_CAP)) u_port_f (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .data(f_data_r),
    .dir(f_dir_r),
    .opt(f_opt_r),
    .alt_val(alt_f_val & alt_f_en),
    .alt_en(alt_f_en),
    .analog(8'h00),
    .pad_in(pad_f_in),
    .pad_out(pad_f_out),
    .pad_oe_n(pad_f_oe_n),
    .pad_pu(pad_f_pu),
    .pin_level(f_lvl),
    .ext_int(ext_int_f)
  );

  // ***************************************************************
  // Motor input selection.
  // ***************************************************************
  always_comb begin
    amp_lvl_nxt = (amp_sync_r[1] == amp_sync_r[2]) ? amp_sync_r[2] :
      amp_lvl_r;
    // Small packages lack the port pin route, so the amp pad is fixed.
    if (PKG_GE56 && !fault_sel_r) begin
      fault_nxt = c_lvl[MTRMUX_BIT_GEN_PC];
    end else begin
      fault_nxt = amp_lvl_r;
    end
    if (PKG_GE56) begin
      zc_nxt = f_lvl[MTRMUX_BIT_ZC_PF];
      dm_nxt = f_lvl[MTRMUX_BIT_DM_PF];
    end else begin
      zc_nxt = d_lvl[MTRMUX_BIT_ZC_PD];
      dm_nxt = d_lvl[MTRMUX_BIT_DM_PD];
    end
  end

  assign current_fault_input = fault_r;
  assign zero_cross_input = zc_r;
  assign demag_input = dm_r;

  // ***************************************************************
  // Register slave.
  // ***************************************************************
  // Writes land on the edge at which the master sees ack.
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;

  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    {c_data_nxt, c_dir_nxt, c_opt_nxt} = {c_data_r, c_dir_r, c_opt_r};
    {d_data_nxt, d_dir_nxt, d_opt_nxt} = {d_data_r, d_dir_r, d_opt_r};
    {f_data_nxt, f_dir_nxt, f_opt_nxt} = {f_data_r, f_dir_r, f_opt_r};
    fault_sel_nxt = fault_sel_r;
    cke_nxt = cke_r;
    dac_nxt = dac_r;
    if (wr_fire) begin
      case (wb_adr_i)
        MTRMUX_OFF_PC_DATA: c_data_nxt = wb_dat_i[7:0];
        MTRMUX_OFF_PC_DIR: c_dir_nxt = wb_dat_i[7:0];
        MTRMUX_OFF_PC_OPT: c_opt_nxt = wb_dat_i[7:0];
        MTRMUX_OFF_PD_DATA: d_data_nxt = wb_dat_i[7:0];
        MTRMUX_OFF_PD_DIR: d_dir_nxt = wb_dat_i[7:0];
        MTRMUX_OFF_PD_OPT: d_opt_nxt = wb_dat_i[7:0];
        MTRMUX_OFF_PF_DATA: f_data_nxt = wb_dat_i[7:0];
        MTRMUX_OFF_PF_DIR: f_dir_nxt = wb_dat_i[7:0];
        MTRMUX_OFF_PF_OPT: f_opt_nxt = wb_dat_i[7:0];
        MTRMUX_OFF_MOTOR_REFERENCE_REGISTER: fault_sel_nxt = wb_dat_i[MTRMUX_BIT_FAULT_SEL];
        MTRMUX_OFF_MOTOR_CONTROL_REGISTER_A: begin
          cke_nxt = wb_dat_i[MTRMUX_BIT_CKE];
          dac_nxt = wb_dat_i[MTRMUX_BIT_DAC];
        end
        default: ;
      endcase
    end
    case (wb_adr_i)
      MTRMUX_OFF_PC_DATA: rd_nxt = {24'h0, c_data_r};
      MTRMUX_OFF_PC_DIR: rd_nxt = {24'h0, c_dir_r};
      MTRMUX_OFF_PC_OPT: rd_nxt = {24'h0, c_opt_r};
      MTRMUX_OFF_PD_DATA: rd_nxt = {24'h0, d_data_r};
      MTRMUX_OFF_PD_DIR: rd_nxt = {24'h0, d_dir_r};
      MTRMUX_OFF_PD_OPT: rd_nxt = {24'h0, d_opt_r};
      MTRMUX_OFF_PF_DATA: rd_nxt = {24'h0, f_data_r};
      MTRMUX_OFF_PF_DIR: rd_nxt = {24'h0, f_dir_r};
      MTRMUX_OFF_PF_OPT: rd_nxt = {24'h0, f_opt_r};
      MTRMUX_OFF_MOTOR_REFERENCE_REGISTER: rd_nxt = {31'h0, fault_sel_r};
      MTRMUX_OFF_MOTOR_CONTROL_REGISTER_A: rd_nxt = {30'h0, dac_r, cke_r};
      MTRMUX_OFF_PIN_C: rd_nxt = {24'h0, c_lvl};
      MTRMUX_OFF_PIN_D: rd_nxt = {24'h0, d_lvl};
      MTRMUX_OFF_PIN_F: rd_nxt = {24'h0, f_lvl};
      MTRMUX_OFF_MIN: rd_nxt = {29'h0, dm_r, zc_r, fault_r};
      default: rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_data_r <= MTRMUX_DATA_RST;
      c_dir_r <= MTRMUX_DIR_RST;
      c_opt_r <= PC_OPT_RST;
      d_data_r <= MTRMUX_DATA_RST;
      d_dir_r <= MTRMUX_DIR_RST;
      d_opt_r <= PD_OPT_RST;
      f_data_r <= MTRMUX_DATA_RST;
      f_dir_r <= MTRMUX_DIR_RST;
      f_opt_r <= PF_OPT_RST;
      fault_sel_r <= MTRMUX_FAULT_SEL_RST;
      cke_r <= 1'b0;
      dac_r <= 1'b0;
      ack_r <= 1'b0;
      rd_r <= 32'h0;
      amp_sync_r <= 3'h0;
      amp_lvl_r <= 1'b0;
      fault_r <= 1'b0;
      zc_r <= 1'b0;
      dm_r <= 1'b0;
    end else begin
      {c_data_r, c_dir_r, c_opt_r} <= {c_data_nxt, c_dir_nxt, c_opt_nxt};
      {d_data_r, d_dir_r, d_opt_r} <= {d_data_nxt, d_dir_nxt, d_opt_nxt};
      {f_data_r, f_dir_r, f_opt_r} <= {f_data_nxt, f_dir_nxt, f_opt_nxt};
      fault_sel_r <= fault_sel_nxt;
      cke_r <= cke_nxt;
      dac_r <= dac_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      amp_sync_r <= {amp_sync_r[1:0], amplifier_output_pad};
      amp_lvl_r <= amp_lvl_nxt;
      fault_r <= fault_nxt;
      zc_r <= zc_nxt;
      dm_r <= dm_nxt;
    end
  end

endmodule // mtrmux_top

// File: verif/mtrmux_top_chk.sv
`timescale 1ns/1ps
// ***************************************************************
// Port-level checker for the pad multiplexer.
// ***************************************************************
module mtrmux_top_chk #(
  parameter int PKG_PINS = 80,
  parameter logic [7:0] PF_BONDED = 8'hff
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic phase_v_pwm_out,
  input wire logic phase_v_pwm_en,
  input wire logic [7:0] alt_c_val,
  input wire logic [7:0] alt_c_en,
  input wire logic amplifier_output_pad,
  input wire logic [7:0] pad_c_in,
  input wire logic [7:0] pad_c_out,
  input wire logic [7:0] pad_c_oe_n,
  input wire logic [7:0] pad_c_pu,
  input wire logic [7:0] pad_d_in,
  input wire logic [7:0] pad_f_in,
  input wire logic [7:0] pad_f_oe_n,
  input wire logic [7:0] pad_f_pu,
  input wire logic current_fault_input,
  input wire logic zero_cross_input,
  input wire logic shared_pin_to_motor
);
  import mtrmux_pkg::*;
  logic sel_r, sel_nxt, wr_ok, fsrc, zsrc;
  logic [1:0] mot_r, mot_nxt;
  // Register state is rebuilt from bus writes, so no internal probe is
  // needed; a write lands at the acknowledging edge.
  assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign fsrc = (sel_r || PKG_PINS < 56) ? amplifier_output_pad : pad_c_in[1];
  assign zsrc = (PKG_PINS >= 56) ? pad_f_in[1] : pad_d_in[2];
  always_comb begin
    sel_nxt = sel_r;
    mot_nxt = mot_r;
    if (wr_ok && wb_adr_i == MTRMUX_OFF_MOTOR_REFERENCE_REGISTER) sel_nxt = wb_dat_i[0];
    if (wr_ok && wb_adr_i == MTRMUX_OFF_MOTOR_CONTROL_REGISTER_A) mot_nxt = wb_dat_i[1:0];
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= MTRMUX_FAULT_SEL_RST;
      mot_r <= 2'h0;
    end else begin
      sel_r <= sel_nxt;
      mot_r <= mot_nxt;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  or_two_alt_a: assert property (PKG_PINS >= 64 && phase_v_pwm_en &&
    alt_c_en[6] |-> !pad_c_oe_n[6] && pad_c_out[6] ==
    (phase_v_pwm_out | alt_c_val[6])) else $error("alternate outputs not ORed");
  phase_v_a: assert property (PKG_PINS >= 64 && phase_v_pwm_en &&
    !alt_c_en[6] |-> !pad_c_oe_n[6] && pad_c_out[6] == phase_v_pwm_out)
    else $error("phase V not on its pad");
  fault_src_a: assert property ($stable(fsrc) [*7] |->
    current_fault_input == fsrc) else $error("fault input from wrong pad");
  motor_flag_a: assert property (shared_pin_to_motor == (mot_r != 2'h0))
    else $error("shared pin hand-over wrong");
  shared_off_a: assert property (shared_pin_to_motor && !alt_c_en[4] |->
    pad_c_oe_n[4] && !pad_c_pu[4]) else $error("shared pin still used as io");
  unbonded_pu_a: assert property ($rose(rst_n) |->
    (pad_f_pu & ~PF_BONDED) == ~PF_BONDED && (pad_f_oe_n | PF_BONDED) == 8'hff)
    else $error("unbonded pad not pulled-up input");
  zc_route_a: assert property ($stable(zsrc) [*7] |->
    zero_cross_input == zsrc) else $error("zero-cross input from wrong pad");
  cover property (shared_pin_to_motor);
  cover property (!sel_r && current_fault_input);
  cover property (phase_v_pwm_en && alt_c_en[6]);
endmodule // mtrmux_top_chk

bind mtrmux_top mtrmux_top_chk #(.PKG_PINS(PKG_PINS), .PF_BONDED(PF_BONDED))
  chk_u (.*);

// File: verif/mtrmux_board.sv
`timescale 1ns/1ps
// ***************************************************************
// Board circuitry on one eight-pad port.
// ***************************************************************
module mtrmux_board (
  input wire logic core_clk,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] out,
  input wire logic [7:0] pu,
  input wire logic [7:0] drv,
  input wire logic [7:0] drv_en,
  output logic [7:0] pad_in
);
  logic flt_r = 1'h0;
  logic flt_nxt;
  // A floating pad toggles every cycle so a stale level never passes.
  always_comb flt_nxt = ~flt_r;
  always_ff @(posedge core_clk) flt_r <= flt_nxt;
  assign pad_in = (~oe_n & out) | (oe_n & drv_en & drv) |
    (oe_n & ~drv_en & (pu | {8{flt_r}}));
endmodule // mtrmux_board

// File: verif/motor_pin_alternate_mux_tb.sv
`timescale 1ns/1ps
// ***************************************************************
// Self-checking bench for the pad multiplexer.
// ***************************************************************
module motor_pin_alternate_mux_tb;
  import mtrmux_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [31:0] w;
    logic [7:0] e;
  } mtrmux_row_t;
  logic core_clk = 1'h0, rst_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0, phase_v_pwm_out = 1'h0, phase_v_pwm_en = 1'h0;
  logic phase_w_pwm_out = 1'h0, phase_w_pwm_en = 1'h0;
  logic amplifier_output_pad = 1'h0, wb_ack_o, current_fault_input;
  logic zero_cross_input, demag_input, shared_pin_to_motor;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdv;
  logic [7:0] wb_adr_i = 8'h00, alt_c_val = 8'h00, alt_c_en = 8'h00;
  logic [7:0] alt_d_val = 8'h00, alt_d_en = 8'h00, alt_f_val = 8'h00;
  logic [7:0] alt_f_en = 8'h00, dv_c = 8'h00, de_c = 8'h00, dv_d = 8'h00;
  logic [7:0] de_d = 8'h00, dv_f = 8'h00, de_f = 8'h00;
  logic [7:0] pad_c_in, pad_c_out, pad_c_oe_n, pad_c_pu, pad_d_in, pad_d_out;
  logic [7:0] pad_d_oe_n, pad_d_pu, pad_f_in, pad_f_out, pad_f_oe_n, pad_f_pu;
  logic [7:0] ext_int_c, ext_int_d, ext_int_f;
  int n_fail = 0, n_tests = 0;
  mtrmux_row_t rows [13] = '{'{8'h00, 32'hffffff5a, 8'h5a},
    '{8'h04, 32'h0, 8'h00}, '{8'h08, 32'h3c, 8'h3c}, '{8'h0c, 32'h11, 8'h11},
    '{8'h10, 32'h0, 8'h00}, '{8'h14, 32'h08, 8'h08}, '{8'h18, 32'h77, 8'h77},
    '{8'h1c, 32'h0, 8'h00}, '{8'h20, 32'hc0, 8'hc0}, '{8'h24, 32'h1, 8'h01},
    '{8'h28, 32'h3, 8'h03}, '{8'h3c, 32'hff, 8'h00}, '{8'h28, 32'h0, 8'h00}};
  mtrmux_top #(.PF_BONDED(8'h3f)) dut_u (.*);
  mtrmux_board brd_c_u (.core_clk(core_clk), .oe_n(pad_c_oe_n),
    .out(pad_c_out), .pu(pad_c_pu), .drv(dv_c), .drv_en(de_c), .pad_in(pad_c_in));
  mtrmux_board brd_d_u (.core_clk(core_clk), .oe_n(pad_d_oe_n),
    .out(pad_d_out), .pu(pad_d_pu), .drv(dv_d), .drv_en(de_d), .pad_in(pad_d_in));
  mtrmux_board brd_f_u (.core_clk(core_clk), .oe_n(pad_f_oe_n),
    .out(pad_f_out), .pu(pad_f_pu), .drv(dv_f), .drv_en(de_f), .pad_in(pad_f_in));
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'h1);
    r = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d, 4'hf, rdv);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0, 4'hf, rdv);
    chk(rdv, e);
  endtask
  task automatic wt();
    repeat (8) @(posedge core_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    results();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    rdc(MTRMUX_OFF_MOTOR_REFERENCE_REGISTER, 32'h1);
    rdc(MTRMUX_OFF_PF_OPT, 32'hc0);
    chk({pad_f_pu & 8'hc0, pad_f_oe_n & 8'hc0}, 32'hc0c0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, {24'h0, rows[i].e});
    end
    wr(MTRMUX_OFF_PC_DIR, 32'h0f);
    chk({pad_c_oe_n, pad_c_out & 8'h0d, pad_c_pu & 8'hf0}, 32'hf20830);
    wb(1'h1, MTRMUX_OFF_PC_DATA, 32'h0, 4'he, rdv);
    rdc(MTRMUX_OFF_PC_DATA, 32'h5a);
    wr(MTRMUX_OFF_MOTOR_CONTROL_REGISTER_A, 32'h2);
    wr(MTRMUX_OFF_PC_DIR, 32'h1f);
    chk({shared_pin_to_motor, pad_c_oe_n[4], pad_c_pu[4]}, 32'h6);
    de_c <= 8'h10;
    dv_c <= 8'h10;
    wt();
    wb(1'h0, MTRMUX_OFF_PIN_C, 32'h0, 4'hf, rdv);
    chk(rdv & 32'h10, 32'h0);
    wr(MTRMUX_OFF_MOTOR_CONTROL_REGISTER_A, 32'h1);
    chk(shared_pin_to_motor, 32'h1);
    wr(MTRMUX_OFF_MOTOR_CONTROL_REGISTER_A, 32'h0);
    chk({pad_c_oe_n[4], pad_c_out[4]}, 32'h1);
    phase_v_pwm_en <= 1'h1;
    phase_v_pwm_out <= 1'h1;
    phase_w_pwm_en <= 1'h1;
    phase_w_pwm_out <= 1'h0;
    @(posedge core_clk);
    chk({pad_c_oe_n[7:6], pad_c_out[7:6]}, 32'h1);
    alt_c_en <= 8'h40;
    for (int i = 0; i < 4; i++) begin
      phase_v_pwm_out <= i[0];
      alt_c_val <= {1'h0, i[1], 6'h00};
      @(posedge core_clk);
      chk({pad_c_oe_n[6], pad_c_out[6]}, 32'(i[0] | i[1]));
    end
    alt_d_en <= 8'h80;
    alt_d_val <= 8'h80;
    amplifier_output_pad <= 1'h1;
    de_c <= 8'h02;
    wt();
    chk({pad_d_oe_n[7], pad_d_out[7]}, 32'h1);
    chk(current_fault_input, 32'h1);
    wr(MTRMUX_OFF_MOTOR_REFERENCE_REGISTER, 32'h0);
    wt();
    chk(current_fault_input, 32'h0);
    dv_c <= 8'h02;
    amplifier_output_pad <= 1'h0;
    wt();
    chk(current_fault_input, 32'h1);
    de_f <= 8'h03;
    alt_f_en <= 8'h20;
    alt_f_val <= 8'h20;
    for (int i = 1; i < 3; i++) begin
      dv_f <= 8'(i);
      wt();
      chk({zero_cross_input, demag_input}, 32'(i));
    end
    chk({pad_f_oe_n, pad_f_out, ext_int_c, ext_int_f}, 32'hdf200000);
    de_d <= 8'h09;
    dv_d <= 8'h09;
    wt();
    chk({ext_int_d & 8'h09, pad_d_pu & 8'h08}, 32'h0808);
    wr(MTRMUX_OFF_PD_OPT, 32'h0);
    chk(pad_d_pu & 8'h08, 32'h0);
    rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    rdc(MTRMUX_OFF_MOTOR_CONTROL_REGISTER_A, 32'h0);
    rdc(MTRMUX_OFF_MOTOR_REFERENCE_REGISTER, 32'h1);
    results();
  end
endmodule // motor_pin_alternate_mux_tb
